// file: hdl/dcx_pkg.sv
package dcx_pkg;

    // ****************************************
    // register map (byte addresses)
    // ****************************************
    localparam logic [11:0] ADDR_CTRL = 12'h000;
    localparam logic [11:0] ADDR_ROOT_LO = 12'h004;
    localparam logic [11:0] ADDR_ROOT_HI = 12'h008;
    localparam logic [11:0] ADDR_CTX_W0 = 12'h00C;
    localparam logic [11:0] ADDR_CTX_W1 = 12'h010;
    localparam logic [11:0] ADDR_CTX_W2 = 12'h014;
    localparam logic [11:0] ADDR_CTX_W3 = 12'h018;
    localparam logic [11:0] ADDR_REQ = 12'h01C;
    localparam logic [11:0] ADDR_STATUS = 12'h020;
    localparam logic [11:0] ADDR_RESULT_TAG = 12'h024;
    localparam logic [11:0] ADDR_RESULT_PTR_LO = 12'h028;
    localparam logic [11:0] ADDR_RESULT_PTR_HI = 12'h02C;
    localparam logic [11:0] ADDR_CAP = 12'h030;

    // ****************************************
    // field positions
    // ****************************************
    // ctrl register
    localparam int CTRL_CACHING_MODE_BIT = 0;
    localparam int CTRL_TAG_WIDTH_LSB = 8;
    localparam int CTRL_TAG_WIDTH_W = 5;
    // request register
    localparam int REQ_START_BIT = 0;
    localparam int REQ_PASID_BIT = 1;
    // status register
    localparam int STAT_BUSY_BIT = 0;
    localparam int STAT_DONE_BIT = 1;
    localparam int STAT_FAULT_BIT = 2;
    localparam int STAT_CODE_LSB = 4;

    // context entry layout
    localparam int CTX_RSVD_HI_MSB = 127;
    localparam int CTX_RSVD_HI_LSB = 88;
    localparam int CTX_TAG_MSB = 87;
    localparam int CTX_TAG_LSB = 72;
    localparam int CTX_RSVD_71 = 71;
    localparam int CTX_DONT_CARE_MSB = 70;
    localparam int CTX_DONT_CARE_LSB = 67;
    localparam int CTX_TTYPE_MSB = 3;
    localparam int CTX_TTYPE_LSB = 2;
    localparam int CTX_PTR_MSB = 63;
    localparam int CTX_PTR_LSB = 12;

    // root entry layout
    localparam int ROOT_PRESENT_BIT = 0;
    localparam int ROOT_PTR_MSB = 63;
    localparam int ROOT_PTR_LSB = 12;

    // ****************************************
    // widths and reset values
    // ****************************************
    localparam int TAG_W = 16;
    localparam logic [4:0] TAG_WIDTH_MAX = 5'h10;
    localparam logic [4:0] TAG_WIDTH_RESET = 5'h10;
    localparam logic [1:0] TTYPE_SL_ONLY = 2'h0;
    localparam logic [1:0] TTYPE_SL_DEV = 2'h1;
    localparam int CTX_TABLE_SHIFT = 12;
    localparam int CTX_ENTRY_SHIFT = 4;

    // ****************************************
    // fault codes
    // ****************************************
    localparam logic [2:0] FLT_NONE = 3'h0;
    localparam logic [2:0] FLT_ROOT_ABSENT = 3'h1;
    localparam logic [2:0] FLT_RESERVED = 3'h2;
    localparam logic [2:0] FLT_ZERO_TAG = 3'h3;
    localparam logic [2:0] FLT_PASID = 3'h4;

    // ****************************************
    // types
    // ****************************************
    typedef enum logic [1:0] {
        DCX_IDLE,
        DCX_CHECK,
        DCX_DONE
    } dcx_state_e;

    typedef struct packed {
        logic ok;
        logic [2:0] code;
        logic [TAG_W-1:0] domain_tag;
        logic [63:0] second_level_table_pointer;
    } dcx_result_s;

endpackage

// file: hdl/dcx_entry_check.sv
`timescale 1ns/100ps
// purely combinational check of one fetched context entry
module dcx_entry_check (
    // entry and configuration
    input wire logic [127:0] entry,
    input wire logic [4:0] tag_width,
    input wire logic caching_mode_flag,
    // outcome
    output dcx_pkg::dcx_result_s result
);

    logic [dcx_pkg::TAG_W-1:0] tag_mask;
    logic [dcx_pkg::TAG_W-1:0] raw_tag;
    logic rsvd_bad;
    logic tag_bad;

    // one mask bit per implemented tag bit
    genvar gi;
    generate
        for (gi = 0; gi < dcx_pkg::TAG_W; gi++) begin : g_mask
            assign tag_mask[gi] = (5'(gi) < tag_width);
        end
    endgenerate

    assign raw_tag = entry[dcx_pkg::CTX_TAG_MSB:dcx_pkg::CTX_TAG_LSB];

    // bits 70:67 never enter any term below
    always_comb begin
        rsvd_bad = (|entry[dcx_pkg::CTX_RSVD_HI_MSB:dcx_pkg::CTX_RSVD_HI_LSB])
                 | entry[dcx_pkg::CTX_RSVD_71];
        tag_bad = |(raw_tag & ~tag_mask);
        result = '0;
        result.domain_tag = raw_tag & tag_mask;
        result.second_level_table_pointer = {entry[dcx_pkg::CTX_PTR_MSB:dcx_pkg::CTX_PTR_LSB], 12'h000};
        if (rsvd_bad || tag_bad) begin
            result.code = dcx_pkg::FLT_RESERVED;
        end else if (caching_mode_flag && (result.domain_tag == '0)) begin
            // software was told not to do this; refuse rather than alias tag zero
            result.code = dcx_pkg::FLT_ZERO_TAG;
        end else begin
            result.ok = 1'b1;
            result.code = dcx_pkg::FLT_NONE;
        end
        if (entry[dcx_pkg::CTX_TTYPE_MSB:dcx_pkg::CTX_TTYPE_LSB] != dcx_pkg::TTYPE_SL_ONLY &&
            entry[dcx_pkg::CTX_TTYPE_MSB:dcx_pkg::CTX_TTYPE_LSB] != dcx_pkg::TTYPE_SL_DEV) begin
            result.second_level_table_pointer = '0;
        end
    end

endmodule

// file: hdl/dcx_context_decode.sv
// The placing of the registers and the APB interface to the registers were decided locally.
`timescale 1ns/100ps
// Overview of operation
// - only requests without a process address space id use context entries.
// - entries are found through the root entry of the requester's bus.
// - entry bits 127:88 and 71 are reserved and must be zero.
// - domain tag is taken from entry bits 87:72.
// - translation caches may be labelled with the decoded domain tag.
// - implemented tag width is reported in the capability register.
// - tag bits above the implemented width are treated as reserved.
// - entry bits 70:67 are disregarded.
// - present root entry bits 63:12 locate a 4KB aligned context table.
// - for type 00b or 01b the second-level pointer is bits 63:12.
module dcx_context_decode (
    // clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // apb slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // requester bus (not used by the decode) and device/function for the lookup
    input wire logic [7:0] req_bus,
    input wire logic [7:0] req_devfn,
    // entry address and cache label
    output logic [63:0] entry_addr,
    output logic [15:0] cache_tag,
    output logic cache_tag_valid
);

    // ****************************************
    // software visible state
    // ****************************************
    logic caching_mode_flag;
    logic [4:0] tag_width;
    logic [63:0] root_entry;
    logic [127:0] ctx_entry;
    logic busy;
    logic done;
    logic fault;
    logic pasid_req;
    logic [2:0] fault_code;
    dcx_pkg::dcx_result_s held;
    dcx_pkg::dcx_state_e state;

    dcx_pkg::dcx_result_s chk;
    logic wr_acc;
    logic rd_acc;
    logic start_pulse;
    logic [4:0] wr_width;

    assign wr_acc = psel && penable && pwrite;
    assign rd_acc = psel && penable && !pwrite;
    assign start_pulse = wr_acc && (paddr == dcx_pkg::ADDR_REQ) && pwdata[dcx_pkg::REQ_START_BIT];
    assign wr_width = pwdata[dcx_pkg::CTRL_TAG_WIDTH_LSB +: dcx_pkg::CTRL_TAG_WIDTH_W];

    dcx_entry_check u_check (
        .entry(ctx_entry),
        .tag_width(tag_width),
        .caching_mode_flag(caching_mode_flag),
        .result(chk)
    );

    // ****************************************
    // configuration writes
    // ****************************************
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            caching_mode_flag <= 1'b0;
            tag_width <= dcx_pkg::TAG_WIDTH_RESET;
        end else if (wr_acc && paddr == dcx_pkg::ADDR_CTRL) begin
            caching_mode_flag <= pwdata[dcx_pkg::CTRL_CACHING_MODE_BIT];
            // out-of-range widths clamp so the mask never grows past the field
            if (wr_width > dcx_pkg::TAG_WIDTH_MAX) begin
                tag_width <= dcx_pkg::TAG_WIDTH_MAX;
            end else begin
                tag_width <= wr_width;
            end
        end
    end

    // entry words are writable only while busy is low (idle or done) so a check sees a stable entry
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            root_entry <= '0;
            ctx_entry <= '0;
        end else if (wr_acc && !busy) begin
            if (paddr == dcx_pkg::ADDR_ROOT_LO) begin
                root_entry[31:0] <= pwdata;
            end else if (paddr == dcx_pkg::ADDR_ROOT_HI) begin
                root_entry[63:32] <= pwdata;
            end else if (paddr == dcx_pkg::ADDR_CTX_W0) begin
                ctx_entry[31:0] <= pwdata;
            end else if (paddr == dcx_pkg::ADDR_CTX_W1) begin
                ctx_entry[63:32] <= pwdata;
            end else if (paddr == dcx_pkg::ADDR_CTX_W2) begin
                ctx_entry[95:64] <= pwdata;
            end else if (paddr == dcx_pkg::ADDR_CTX_W3) begin
                ctx_entry[127:96] <= pwdata;
            end
        end
    end

    // ****************************************
    // lookup sequence
    // ****************************************
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state <= dcx_pkg::DCX_IDLE;
            busy <= 1'b0;
            done <= 1'b0;
            fault <= 1'b0;
            fault_code <= dcx_pkg::FLT_NONE;
            pasid_req <= 1'b0;
            held <= '0;
            entry_addr <= '0;
        end else begin
            case (state)
                dcx_pkg::DCX_IDLE: begin
                    if (start_pulse) begin
                        busy <= 1'b1;
                        done <= 1'b0;
                        fault <= 1'b0;
                        pasid_req <= pwdata[dcx_pkg::REQ_PASID_BIT];
                        // the entry is reached from this bus's root, never directly
                        entry_addr <= {root_entry[dcx_pkg::ROOT_PTR_MSB:dcx_pkg::ROOT_PTR_LSB],
                                       req_devfn, 4'h0};
                        state <= dcx_pkg::DCX_CHECK;
                    end
                end
                dcx_pkg::DCX_CHECK: begin
                    busy <= 1'b0;
                    done <= 1'b1;
                    state <= dcx_pkg::DCX_DONE;
                    if (pasid_req) begin
                        fault <= 1'b1;
                        fault_code <= dcx_pkg::FLT_PASID;
                        held <= '0;
                    end else if (!root_entry[dcx_pkg::ROOT_PRESENT_BIT]) begin
                        fault <= 1'b1;
                        fault_code <= dcx_pkg::FLT_ROOT_ABSENT;
                        held <= '0;
                    end else if (!chk.ok) begin
                        fault <= 1'b1;
                        fault_code <= chk.code;
                        held <= '0;
                    end else begin
                        fault_code <= dcx_pkg::FLT_NONE;
                        held <= chk;
                    end
                end
                dcx_pkg::DCX_DONE: begin
                    state <= dcx_pkg::DCX_IDLE;
                end
                default: begin
                    state <= dcx_pkg::DCX_IDLE;
                end
            endcase
        end
    end

    // cache label follows the last decode, cleared to zero and invalid by a refused one
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cache_tag <= '0;
            cache_tag_valid <= 1'b0;
        end else if (state == dcx_pkg::DCX_CHECK) begin
            cache_tag_valid <= chk.ok && !pasid_req && root_entry[dcx_pkg::ROOT_PRESENT_BIT];
            if (chk.ok && !pasid_req && root_entry[dcx_pkg::ROOT_PRESENT_BIT]) begin
                cache_tag <= chk.domain_tag;
            end else begin
                // a refused entry must not label any cache line
                cache_tag <= '0;
            end
        end
    end

    // ****************************************
    // apb response path, zero-wait answer
    // ****************************************
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata <= '0;
            pready <= 1'b0;
            pslverr <= 1'b0;
        end else begin
            // pready is registered from setup, so it is high in the first access cycle and each access completes there
            pready <= psel && !penable;
            pslverr <= 1'b0;
            prdata <= '0;
            if (psel && !penable && !pwrite) begin
                if (paddr == dcx_pkg::ADDR_CTRL) begin
                    prdata <= {19'h0_0000, tag_width, 7'h00, caching_mode_flag};
                end else if (paddr == dcx_pkg::ADDR_ROOT_LO) begin
                    prdata <= root_entry[31:0];
                end else if (paddr == dcx_pkg::ADDR_ROOT_HI) begin
                    prdata <= root_entry[63:32];
                end else if (paddr == dcx_pkg::ADDR_CTX_W0) begin
                    prdata <= ctx_entry[31:0];
                end else if (paddr == dcx_pkg::ADDR_CTX_W1) begin
                    prdata <= ctx_entry[63:32];
                end else if (paddr == dcx_pkg::ADDR_CTX_W2) begin
                    prdata <= ctx_entry[95:64];
                end else if (paddr == dcx_pkg::ADDR_CTX_W3) begin
                    prdata <= ctx_entry[127:96];
                end else if (paddr == dcx_pkg::ADDR_REQ) begin
                    prdata <= {31'h0000_0000, pasid_req} << dcx_pkg::REQ_PASID_BIT;
                end else if (paddr == dcx_pkg::ADDR_STATUS) begin
                    prdata <= {25'h000_0000, fault_code, 1'b0, fault, done, busy};
                end else if (paddr == dcx_pkg::ADDR_RESULT_TAG) begin
                    prdata <= {16'h0000, held.domain_tag};
                end else if (paddr == dcx_pkg::ADDR_RESULT_PTR_LO) begin
                    prdata <= held.second_level_table_pointer[31:0];
                end else if (paddr == dcx_pkg::ADDR_RESULT_PTR_HI) begin
                    prdata <= held.second_level_table_pointer[63:32];
                end else if (paddr == dcx_pkg::ADDR_CAP) begin
                    prdata <= {27'h000_0000, tag_width};
                end else begin
                    pslverr <= 1'b1;
                end
            end else if (psel && !penable) begin
                if (paddr > dcx_pkg::ADDR_CAP || paddr[1:0] != 2'b00 ||
                    paddr == dcx_pkg::ADDR_STATUS || paddr == dcx_pkg::ADDR_RESULT_TAG ||
                    paddr == dcx_pkg::ADDR_RESULT_PTR_LO || paddr == dcx_pkg::ADDR_RESULT_PTR_HI ||
                    paddr == dcx_pkg::ADDR_CAP) begin
                    pslverr <= 1'b1;
                end
            end
        end
    end

endmodule

// file: testbench/dcx_checker.sv
`timescale 1ns/100ps
// ****
// apb timing and lookup result checks
// ****
module dcx_checker (
    // clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // apb
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic pready,
    input wire logic pslverr,
    // lookup
    input wire logic [7:0] req_devfn,
    input wire logic [63:0] entry_addr,
    input wire logic [15:0] cache_tag,
    input wire logic cache_tag_valid
);
    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn);
    logic [2:0] gap;
    wire start_wr = psel && penable && pwrite && paddr == dcx_pkg::ADDR_REQ && pwdata[0];
    // a start is taken once the previous lookup is back in idle, three edges later
    wire start_ok = start_wr && gap >= 3'h2;
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            gap <= 3'h7;
        end else if (start_wr) begin
            gap <= 3'h0;
        end else if (gap != 3'h7) begin
            gap <= gap + 3'h1;
        end
    end
    sequence s_setup;
        psel && !penable;
    endsequence
    sequence s_access;
        psel && penable && $past(psel && !penable);
    endsequence
    property p_ready_next;
        s_setup |=> pready;
    endproperty
    property p_ready_only;
        pready |-> s_access;
    endproperty
    property p_ready_pulse;
        pready |=> !pready;
    endproperty
    property p_err_with_ready;
        pslverr |-> pready;
    endproperty
    property p_unmapped;
        s_setup ##0 (paddr > dcx_pkg::ADDR_CAP || paddr[1:0] != 2'h0) |=> pslverr;
    endproperty
    property p_entry_addr;
        start_ok |=> entry_addr[11:0] == {$past(req_devfn), 4'h0};
    endproperty
    property p_addr_hold;
        $changed(entry_addr) |-> $past(start_ok);
    endproperty
    property p_pasid;
        start_ok && pwdata[1] |=> ##1 !cache_tag_valid && cache_tag == 16'h0000;
    endproperty
    property p_tag_hold;
        $changed(cache_tag) || $changed(cache_tag_valid) |-> $past(start_ok, 2);
    endproperty
    property p_fault_zero;
        !cache_tag_valid |-> cache_tag == 16'h0000;
    endproperty
    a_ready_next: assert property (p_ready_next) else $error("pready missing after setup");
    a_ready_only: assert property (p_ready_only) else $error("pready outside access");
    a_ready_pulse: assert property (p_ready_pulse) else $error("pready longer than one cycle");
    a_err_with_ready: assert property (p_err_with_ready) else $error("pslverr without pready");
    a_unmapped: assert property (p_unmapped) else $error("bad address not refused");
    a_entry_addr: assert property (p_entry_addr) else $error("entry address wrong");
    a_addr_hold: assert property (p_addr_hold) else $error("entry address moved");
    a_pasid: assert property (p_pasid) else $error("pasid request used entry");
    a_tag_hold: assert property (p_tag_hold) else $error("cache tag moved");
    a_fault_zero: assert property (p_fault_zero) else $error("tag shown on fault");
endmodule
bind dcx_context_decode dcx_checker u_chk (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready), .pslverr(pslverr), .req_devfn(req_devfn),
    .entry_addr(entry_addr), .cache_tag(cache_tag), .cache_tag_valid(cache_tag_valid));

// file: testbench/dcx_sw_table.sv
`timescale 1ns/100ps
// ****
// software side: well-formed context entry for an entry address
// ****
module dcx_sw_table (
    // lookup
    input wire logic [63:0] addr,
    input wire logic [15:0] tag_mask,
    // entry
    output logic [127:0] entry
);
    logic [15:0] tag;
    always_comb begin
        tag = (addr[19:4] | 16'h0001) & tag_mask;
        entry = '0;
        entry[87:72] = tag;
        entry[63:12] = {36'h0_0000_0000, tag};
        entry[70:67] = addr[9:6];
        entry[3:2] = addr[5:4];
    end
endmodule

// file: testbench/tb_dcx_context_decode.sv
`timescale 1ns/100ps
// ****
// random context entries through the apb port
// ****
module tb_dcx_context_decode;
    logic pclk, presetn, psel, penable, pwrite, pready, pslverr, rerr, cache_tag_valid;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, rdat;
    logic [7:0] req_bus, req_devfn;
    logic [63:0] entry_addr, tbl_addr;
    logic [15:0] cache_tag, tag_mask;
    logic [127:0] tbl_entry;
    int n_mismatch, n_tests, cyc;
    dcx_context_decode DUT (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .req_bus(req_bus),
        .req_devfn(req_devfn), .entry_addr(entry_addr), .cache_tag(cache_tag), .cache_tag_valid(cache_tag_valid));
    dcx_sw_table u_sw (.addr(tbl_addr), .tag_mask(tag_mask), .entry(tbl_entry));
    initial begin
        pclk = 1'b0;
        forever #10 pclk = ~pclk;
    end
    always @(posedge pclk) begin
        cyc++;
        if (cyc == 10000) begin
            n_mismatch++;
            give_verdict();
        end
    end
    task check(input logic [63:0] seen, input logic [63:0] exp);
        n_tests++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("CHECK FAILED at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask
    task give_verdict();
        $display("comparisons %0d, mismatches %0d", n_tests, n_mismatch);
        if (n_mismatch == 0 && n_tests > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask
    // request held until pready, then one idle cycle so psel never toggles twice in a step
    task apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        // only the bench timeout ends a wait for pready
        do begin
            @(posedge pclk);
        end while (pready !== 1'b1);
        rdat = prdata;
        rerr = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge pclk);
    endtask
    task wr(input logic [11:0] a, input logic [31:0] d);
        apb(1'b1, a, d);
        check(rerr, 1'b0);
    endtask
    task rd(input logic [11:0] a, input logic [31:0] exp);
        apb(1'b0, a, 32'h0000_0000);
        check({rerr, rdat}, {1'b0, exp});
    endtask
    function dcx_pkg::dcx_result_s expect_of(input logic [127:0] e, input logic rp, input logic pasid,
                                             input logic [4:0] w, input logic cm);
        dcx_pkg::dcx_result_s r;
        r = '0;
        if (pasid) begin
            r.code = dcx_pkg::FLT_PASID;
        end else if (!rp) begin
            r.code = dcx_pkg::FLT_ROOT_ABSENT;
        end else if (|e[127:88] || e[71] || |(e[87:72] & (16'hFFFF << w))) begin
            r.code = dcx_pkg::FLT_RESERVED;
        end else if (cm && e[87:72] == 16'h0000) begin
            r.code = dcx_pkg::FLT_ZERO_TAG;
        end else begin
            r.ok = 1'b1;
            r.domain_tag = e[87:72];
            if (e[3] == 1'b0) begin
                r.second_level_table_pointer = {e[63:12], 12'h000};
            end
        end
        return r;
    endfunction
    task lookup(input logic [63:0] root, input logic [4:0] w, input logic cm, input logic pasid,
                input int mut, input logic dbl);
        logic [127:0] e;
        logic [7:0] fn;
        dcx_pkg::dcx_result_s r;
        fn = 8'($urandom);
        req_devfn <= fn;
        req_bus <= 8'($urandom);
        tbl_addr <= {root[63:12], fn, 4'h0};
        tag_mask <= ~(16'hFFFF << w);
        wr(dcx_pkg::ADDR_CTRL, 32'({w, 7'h00, cm}));
        rd(dcx_pkg::ADDR_CAP, 32'(w));
        e = tbl_entry;
        case (mut)
            0: e[88 + $urandom_range(0, 39)] = 1'b1;
            1: e[71] = 1'b1;
            2: e[87:72] = 16'h0000;
            3: e[72 + w] = 1'b1;
            4: e[70:67] = ~e[70:67];
            default: ;
        endcase
        wr(dcx_pkg::ADDR_ROOT_LO, root[31:0]);
        wr(dcx_pkg::ADDR_ROOT_HI, root[63:32]);
        for (int k = 0; k < 4; k++) begin
            wr(dcx_pkg::ADDR_CTX_W0 + 12'(4 * k), e[32 * k +: 32]);
        end
        wr(dcx_pkg::ADDR_REQ, {30'h0000_0000, pasid, 1'b1});
        if (dbl) begin
            wr(dcx_pkg::ADDR_REQ, 32'h0000_0003);
        end
        // the second start comes after the first is back in idle, so it is taken and asks with pasid
        r = expect_of(e, root[0], pasid | dbl, w, cm);
        rd(dcx_pkg::ADDR_STATUS, 32'({r.code, 1'b0, !r.ok, 2'h2}));
        rd(dcx_pkg::ADDR_RESULT_TAG, 32'(r.domain_tag));
        rd(dcx_pkg::ADDR_RESULT_PTR_LO, r.second_level_table_pointer[31:0]);
        rd(dcx_pkg::ADDR_RESULT_PTR_HI, r.second_level_table_pointer[63:32]);
        check({cache_tag_valid, cache_tag}, {r.ok, r.domain_tag});
        check(entry_addr, {root[63:12], fn, 4'h0});
    endtask
    initial begin
        presetn = 1'b0;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 12'h000;
        pwdata = 32'h0000_0000;
        req_bus = 8'h00;
        req_devfn = 8'h00;
        tbl_addr = 64'h0000_0000_0000_0000;
        tag_mask = 16'hFFFF;
        void'($urandom(95611));
        repeat (12) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        rd(dcx_pkg::ADDR_CTRL, 32'h0000_1000);
        rd(dcx_pkg::ADDR_STATUS, 32'h0000_0000);
        apb(1'b0, 12'h034, 32'h0000_0000);
        check(rerr, 1'b1);
        apb(1'b0, 12'h002, 32'h0000_0000);
        check(rerr, 1'b1);
        apb(1'b1, dcx_pkg::ADDR_CAP, 32'h0000_0004);
        check(rerr, 1'b1);
        rd(dcx_pkg::ADDR_CAP, 32'h0000_0010);
        wr(dcx_pkg::ADDR_CTRL, 32'h0000_1F00);
        rd(dcx_pkg::ADDR_CAP, 32'h0000_0010);
        for (int i = 0; i < 40; i++) begin
            lookup({32'($urandom), 20'($urandom), 11'h000, 1'(i % 7 != 6)},
                   (i % 3 == 0) ? 5'h08 : (i % 3 == 1) ? 5'h10 : 5'($urandom_range(1, 16)),
                   1'(i[1]), 1'(i % 10 == 9), i % 8, 1'(i == 5));
        end
        give_verdict();
    end
endmodule
